/* File: bench/bdio_field.sv */
`timescale 1ns/10ps
`default_nettype none
// field modules on the pins: output modules echo the driven level
module bdio_field (
    input wire logic [47:0] line_out,
    input wire logic [47:0] line_oe,
    input wire logic [47:0] stim,
    output logic [47:0] line_in
);
    assign line_in = (line_oe & line_out) | (~line_oe & stim);
endmodule : bdio_field
`default_nettype wire

/* File: bench/bdio_top_sva.sv */
`timescale 1ns/10ps
`default_nettype none
// port checks on the gpio top
module bdio_top_sva (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [47:0] line_out,
    input wire logic [47:0] line_oe,
    input wire logic irq
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire take; // accepted address phase
    logic wr_dp_r; // write data phase running
    assign take = hsel && hready && htrans[1] && ce;
    // remember write address phases
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_dp_r <= 1'b0;
        end else begin
            wr_dp_r <= take && hwrite;
        end
    end
    ////////////////////////////////////////////////////////////
    zero_wait_a: assert property (hreadyout && !hresp)
        else $error("bus not zero-wait okay");
    reset_input_a: assert property (!$past(hresetn) |-> line_oe == 48'h0 && !irq)
        else $error("not all input after reset");
    block_dir_a: assert property (line_oe[15:8] == {8{line_oe[8]}} && line_oe[47:40] == {8{line_oe[40]}})
        else $error("direction split inside a block");
    out_cause_a: assert property ($changed(line_out) |-> $past(wr_dp_r))
        else $error("output moved without a write");
    ce_freeze_a: assert property (!ce |=> $stable(line_out) && $stable(irq))
        else $error("state moved while frozen");
    rd_hold_a: assert property (!(take && !hwrite) |=> $stable(hrdata))
        else $error("read data moved without a read");
    irq_block_a: assert property ($rose(irq) |-> !line_oe[8])
        else $error("interrupt while block 1 drives");
    irq_sticky_a: assert property (irq && !wr_dp_r && !$past(wr_dp_r) |=> irq)
        else $error("interrupt dropped without a write");
    cover property ($rose(irq));
    cover property ($changed(line_out));
    cover property (!ce ##1 ce);
endmodule : bdio_top_sva
`default_nettype wire

/* File: bench/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import bdio_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic ce = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [47:0] stim = 48'h0; // field levels
    logic [7:0] msk = 8'h00; // mask as software set it
    wire [31:0] hrdata;
    wire hreadyout;
    wire hresp;
    wire [47:0] line_in;
    wire [47:0] line_out;
    wire [47:0] line_oe;
    wire irq;
    int error_cnt = 0;
    int samples_checked = 0;
    always #12.5 hclk = ~hclk;
    bdio_top u_dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .line_in(line_in), .line_out(line_out), .line_oe(line_oe), .irq(irq));
    bdio_field u_field (.line_out(line_out), .line_oe(line_oe), .stim(stim), .line_in(line_in));
    ////////////////////////////////////////////////////////////
    // verdict, the only exit
    task automatic wrap_up;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk
    // bounded wait for hready high at an edge
    task automatic wait_rdy;
        for (int n = 0; n < 16; n++) begin
            @(posedge hclk);
            if (hreadyout === 1'b1) return;
        end
        chk("hready", 48'h1, {47'h0, hreadyout});
        wrap_up();
    endtask : wait_rdy
    // single word transfer: address phase, then data phase
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        r = hrdata;
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask : wr
    task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        xfer(1'b0, a, 32'h0, r);
        chk(what, {16'h0, exp}, {16'h0, r});
    endtask : rdc
    function automatic logic [31:0] cmd(input logic [2:0] b, input logic [3:0] d, input bdio_op_t op, input logic [1:0] v);
        cmd = {18'h0, v, op, 1'b0, b, d};
    endfunction : cmd
    // let a committed write reach the pins
    task automatic settle;
        repeat (2) @(posedge hclk);
        #1;
    endtask : settle
    ////////////////////////////////////////////////////////////
    task automatic s_reset;
        chk("oe", 48'h0, line_oe);
        rdc("dir", BDIO_DIR_OFF, 32'h3F);
        wr(8'h4C, 32'hFFFF_FFFF);
        rdc("hole", 8'h4C, 32'h0);
    endtask : s_reset
    task automatic s_blocks;
        wr(BDIO_DIR_OFF, 32'h3C);
        wr(BDIO_OUT0_OFF, 32'hA5);
        wr(BDIO_OUT0_OFF + 8'h4, 32'h3C);
        settle();
        chk("oe", 48'hFFFF, line_oe);
        chk("out", 48'h3CA5, line_out);
        rdc("out0", BDIO_OUT0_OFF, 32'hA5);
    endtask : s_blocks
    // single-line commands against a local copy of block 0
    task automatic s_lines;
        bdio_op_t ops[5] = '{BDIO_OP_ON, BDIO_OP_OFF, BDIO_OP_TOGGLE, BDIO_OP_WRITE, BDIO_OP_WRITE};
        logic [3:0] dg[5] = '{4'h1, 4'h0, 4'h7, 4'h3, 4'h5};
        logic [7:0] m;
        m = 8'hA5;
        for (int i = 0; i < 5; i++) begin
            wr(BDIO_CMD_OFF, cmd(3'h0, dg[i], ops[i], {1'b0, dg[i] == 4'h3}));
            if (ops[i] == BDIO_OP_TOGGLE) m[dg[i]] = ~m[dg[i]];
            else m[dg[i]] = (ops[i] == BDIO_OP_ON) || (ops[i] == BDIO_OP_WRITE && dg[i] == 4'h3);
            settle();
            chk("line", {40'h0, m}, {40'h0, line_out[7:0]});
        end
        // line 3 is high, so selecting line 3 of block 0 reads back high
        wr(BDIO_CMD_OFF, cmd(3'h0, 4'h3, BDIO_OP_SELECT, 2'h0));
        rdc("rdbk", BDIO_RDBK_OFF, {31'h0, m[3]});
        wr(BDIO_CMD_OFF, cmd(3'h2, 4'h0, BDIO_OP_ON, 2'h0));
        wr(BDIO_CMD_OFF, cmd(3'h0, 4'h8, BDIO_OP_ON, 2'h0));
        settle();
        chk("input blk", 48'h0, {40'h0, line_out[23:16]});
        chk("digit 8", {40'h0, m}, {40'h0, line_out[7:0]});
    endtask : s_lines
    // drive one interrupt line, check and clear what it raised
    task automatic ev(input int k, input logic v, input logic [7:0] st, input logic [31:0] src);
        @(posedge hclk);
        stim[8 + k] <= v;
        repeat (8) @(posedge hclk);
        rdc("stat", BDIO_STAT_OFF, {24'h0, st});
        chk("irq", {47'h0, |(st & msk)}, {47'h0, irq});
        if (st != 8'h0) begin
            rdc("src", BDIO_SRC_OFF, src);
            wr(BDIO_STAT_OFF, {24'h0, st});
            repeat (4) @(posedge hclk);
            chk("irq clr", 48'h0, {47'h0, irq});
        end
    endtask : ev
    task automatic s_irq;
        // block 1 back to input, block 0 stays output
        wr(BDIO_DIR_OFF, 32'h3E);
        msk = 8'hFF;
        wr(BDIO_MASK_OFF, 32'hFF);
        wr(BDIO_CMD_OFF, cmd(3'h1, 4'h0, BDIO_OP_IRQ_EN, BDIO_TRIG_RISE));
        wr(BDIO_CMD_OFF, cmd(3'h1, 4'h1, BDIO_OP_IRQ_EN, BDIO_TRIG_BOTH));
        wr(BDIO_CMD_OFF, cmd(3'h1, 4'h2, BDIO_OP_IRQ_EN, BDIO_TRIG_FALL));
        // digit 3 of block 2 would show as enable bit 3 if taken
        wr(BDIO_CMD_OFF, cmd(3'h2, 4'h3, BDIO_OP_IRQ_EN, BDIO_TRIG_RISE));
        rdc("trig", BDIO_TRIG_OFF, 32'h18);
        ev(0, 1'b1, 8'h01, 32'h0710);
        ev(0, 1'b0, 8'h00, 32'h0);
        ev(2, 1'b1, 8'h00, 32'h0);
        ev(2, 1'b0, 8'h04, 32'h0712);
        ev(1, 1'b1, 8'h02, 32'h0711);
        ev(1, 1'b0, 8'h02, 32'h0711);
        msk = 8'hFE;
        wr(BDIO_MASK_OFF, 32'hFE);
        ev(0, 1'b1, 8'h01, 32'h0710);
        wr(BDIO_CMD_OFF, cmd(3'h1, 4'h0, BDIO_OP_IRQ_DIS, 2'h0));
        ev(0, 1'b0, 8'h00, 32'h0);
        ev(0, 1'b1, 8'h00, 32'h0);
        rdc("src dis", BDIO_SRC_OFF, 32'h0610);
        rdc("in1", BDIO_IN0_OFF + 8'h4, 32'h01);
    endtask : s_irq
    task automatic s_ce;
        @(posedge hclk);
        ce <= 1'b0;
        wr(BDIO_OUT0_OFF, 32'h00);
        ce <= 1'b1;
        rdc("frozen", BDIO_OUT0_OFF, 32'h0E);
    endtask : s_ce
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        s_reset();
        s_blocks();
        s_lines();
        s_irq();
        s_ce();
        wrap_up();
    end
endmodule : tb_top
bind bdio_top bdio_top_sva u_sva (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .line_out(line_out), .line_oe(line_oe), .irq(irq));
`default_nettype wire

/* File: rtl/bdio_edge.sv */
`timescale 1ns/10ps
`default_nettype none
// per-line edge detector with selectable trigger type
module bdio_edge (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic s,
    input wire logic [1:0] trig,
    output logic hit
);
    import bdio_pkg::*;
    logic prev_r;
    wire rise = s & ~prev_r;
    wire fall = ~s & prev_r;
    assign hit = ((trig == BDIO_TRIG_RISE) & rise) | ((trig == BDIO_TRIG_FALL) & fall) |
                 ((trig == BDIO_TRIG_BOTH) & (rise | fall));
    ////////////////////////////////////////////////////////////////
    // compare successive samples
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_r <= 1'b0;
        end else if (ce) begin
            prev_r <= s;
        end
    end
endmodule : bdio_edge
`default_nettype wire

/* File: rtl/bdio_pkg.sv */
package bdio_pkg;
    // register byte offsets
    localparam logic [7:0] BDIO_DIR_OFF = 8'h00;
    localparam logic [7:0] BDIO_OUT0_OFF = 8'h04;
    localparam logic [7:0] BDIO_CMD_OFF = 8'h1C;
    localparam logic [7:0] BDIO_STAT_OFF = 8'h20;
    localparam logic [7:0] BDIO_MASK_OFF = 8'h24;
    localparam logic [7:0] BDIO_TRIG_OFF = 8'h28;
    localparam logic [7:0] BDIO_SRC_OFF = 8'h2C;
    localparam logic [7:0] BDIO_IN0_OFF = 8'h30;
    localparam logic [7:0] BDIO_RDBK_OFF = 8'h48;
    // geometry
    localparam int BDIO_NBLK = 6;
    localparam int BDIO_BW = 8;
    localparam logic [2:0] BDIO_IRQ_BLK = 3'h1;
    // reset values
    localparam logic [5:0] BDIO_DIR_RST = 6'h3F;
    localparam logic [7:0] BDIO_OUT_RST = 8'h00;
    localparam logic [15:0] BDIO_TRIG_RST = 16'h0000;
    // command field positions in the command word
    localparam int BDIO_CMD_LINE_LSB = 0;
    localparam int BDIO_CMD_BLK_LSB = 4;
    localparam int BDIO_CMD_OP_LSB = 8;
    localparam int BDIO_CMD_VAL_BIT = 12;
    // single-line command opcodes
    typedef enum logic [3:0] {
        BDIO_OP_NONE = 4'h0,
        BDIO_OP_WRITE = 4'h1,
        BDIO_OP_ON = 4'h2,
        BDIO_OP_OFF = 4'h3,
        BDIO_OP_TOGGLE = 4'h4,
        BDIO_OP_SELECT = 4'h5,
        BDIO_OP_IRQ_EN = 4'h6,
        BDIO_OP_IRQ_DIS = 4'h7
    } bdio_op_t;
    // trigger types
    localparam logic [1:0] BDIO_TRIG_RISE = 2'h0;
    localparam logic [1:0] BDIO_TRIG_FALL = 2'h1;
    localparam logic [1:0] BDIO_TRIG_BOTH = 2'h2;
endpackage : bdio_pkg

/* File: rtl/bdio_sync2.sv */
`timescale 1ns/10ps
`default_nettype none
// two-flop synchroniser, first stage read only by the second
module bdio_sync2 #(
    parameter int W = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;
    ////////////////////////////////////////////////////////////////
    // two stage sync
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_r <= '0;
            q <= '0;
        end else if (ce) begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule : bdio_sync2
`default_nettype wire

/* File: rtl/bdio_top.sv */
// Function
// - six blocks of eight lines each
// - direction per block, 0 out 1 in
// - all blocks input after reset
// - single write drives line to value bit
// - block write sets eight lines together
// - force on and force off commands
// - toggle command inverts one line
// - driven line state can be read back
// - only block 1 lines take interrupts
// - trigger rise, fall or both edges
// - any enabled, unmasked edge of input block 1 raises shared interrupt
// - report line index of firing source
// - disable command stops one line's interrupts
//
// Chosen here: the address map and the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module bdio_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [47:0] line_in,
    output logic [47:0] line_out,
    output logic [47:0] line_oe,
    output logic irq
);
    import bdio_pkg::*;
    localparam int N = BDIO_NBLK * BDIO_BW;
    // one flat vector for all lines: lane b*8+k is line b*10+k
    // the decimal line number exists only in software's view

    ////////////////////////////////////////////////////////////////
    // state
    // configuration written by software
    logic [5:0] dir_r; // 1 = input block
    logic [N-1:0] out_r; // driven output levels
    // interrupt side, block 1 lines only
    logic [7:0] stat_r; // sticky pending per irq line
    logic [7:0] mask_r; // interrupt mask
    logic [7:0] en_r; // per-line irq enable
    logic [15:0] trig_r; // two bits per irq line
    logic [3:0] src_r; // last firing line, low digit
    logic [3:0] sel_r; // line chosen for readback, low digit
    logic [2:0] selb_r; // block chosen for readback
    // address phase capture
    // kept apart from the register state: bus timing only
    logic wr_pend_r; // write data phase in this cycle
    logic [7:0] waddr_r; // byte offset of that write
    logic [N-1:0] in_s; // synchronised pins

    ////////////////////////////////////////////////////////////////
    // bus decode; always zero wait
    // every register answers at once, so hreadyout is tied high
    // and no error response exists; unmapped offsets read zero
    // hsize is ignored: each access is taken as a whole word
    wire ap_valid = hsel & hready & htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    wire wr_now = wr_pend_r & ce;
    wire [31:0] wd = hwdata;
    // write strobes, each already qualified by ce
    wire w_dir = wr_now & (waddr_r == BDIO_DIR_OFF);
    wire w_cmd = wr_now & (waddr_r == BDIO_CMD_OFF);
    wire w_stat = wr_now & (waddr_r == BDIO_STAT_OFF);
    wire w_mask = wr_now & (waddr_r == BDIO_MASK_OFF);
    wire w_trig = wr_now & (waddr_r == BDIO_TRIG_OFF);
    // block output registers sit at OUT0 + 4*blk
    wire [7:0] out_rel = waddr_r - BDIO_OUT0_OFF;
    wire w_blk = wr_now & (waddr_r >= BDIO_OUT0_OFF) & (out_rel[7:2] < 6'(BDIO_NBLK)) &
                 (out_rel[1:0] == 2'h0);
    wire [2:0] w_blk_idx = out_rel[4:2];

    // command word fields
    // digit and block pick one line, op picks the action
    // value bit and trigger field overlap; trigger only counts for enable
    // block numbers 6 and 7 are out of range
    wire [3:0] c_line = wd[BDIO_CMD_LINE_LSB +: 4];
    wire [2:0] c_blk = wd[BDIO_CMD_BLK_LSB +: 3];
    wire [3:0] c_op = wd[BDIO_CMD_OP_LSB +: 4];
    wire c_val = wd[BDIO_CMD_VAL_BIT];
    wire [1:0] c_trig = wd[BDIO_CMD_VAL_BIT +: 2];
    // line index is block*8 + digit; digits 8,9 invalid
    wire c_ok = (c_line < 4'h8) & (c_blk < 3'(BDIO_NBLK));
    wire [5:0] c_pos = 6'({c_blk, c_line[2:0]});
    // write, on, off and toggle commands only act on output blocks
    wire c_outblk = c_ok & ~dir_r[c_blk];
    // interrupt commands valid for block 1 only
    wire c_irqok = c_ok & (c_blk == BDIO_IRQ_BLK);

    ////////////////////////////////////////////////////////////////
    // address phase register
    // the write address is held into its data phase; a frozen
    // cycle keeps a pending write until the clock enable returns
    // waddr_r loads every enabled cycle but only matters with wr_pend_r set
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            waddr_r <= 8'h00;
        end else if (ce) begin
            wr_pend_r <= ap_valid & hwrite;
            waddr_r <= haddr[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////
    // direction; reset to input
    // a block turned to input stops driving its pins at once,
    // the pin enable follows on the same edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dir_r <= BDIO_DIR_RST;
        end else if (w_dir) begin
            dir_r <= wd[5:0];
        end
    end

    ////////////////////////////////////////////////////////////////
    // output next value: one command per cycle at most
    // block write and command cannot meet: one bus write per cycle
    // commands to input blocks are dropped, never queued
    logic [N-1:0] out_nxt;
    always_comb begin
        out_nxt = out_r;
        if (w_blk) begin
            out_nxt[w_blk_idx*BDIO_BW +: BDIO_BW] = wd[7:0];
        end else if (w_cmd && c_outblk) begin
            case (bdio_op_t'(c_op))
                BDIO_OP_WRITE: out_nxt[c_pos] = c_val;
                BDIO_OP_ON: out_nxt[c_pos] = 1'b1;
                BDIO_OP_OFF: out_nxt[c_pos] = 1'b0;
                BDIO_OP_TOGGLE: out_nxt[c_pos] = ~out_r[c_pos];
                // select and interrupt ops leave levels alone
                default: out_nxt = out_r;
            endcase
        end
    end

    // output level register, also the readback source
    // levels survive a direction change, so a block turned back
    // to output resumes where it stopped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_r <= {BDIO_NBLK{BDIO_OUT_RST}};
        end else if (ce) begin
            out_r <= out_nxt;
        end
    end

    // pins: enable follows block direction
    // input blocks keep their held level but never drive it
    genvar g;
    generate
        for (g = 0; g < BDIO_NBLK; g++) begin : g_oe
            assign line_oe[g*BDIO_BW +: BDIO_BW] = {BDIO_BW{~dir_r[g]}};
        end
    endgenerate
    assign line_out = out_r;

    ////////////////////////////////////////////////////////////////
    // readback selector, any line of any block
    // the select op picks the line seen at the readback offset;
    // an input block shows its held, undriven level
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sel_r <= 4'h0;
            selb_r <= 3'h0;
        end else if (w_cmd && c_ok && (bdio_op_t'(c_op) == BDIO_OP_SELECT)) begin
            sel_r <= c_line;
            selb_r <= c_blk;
        end
    end
    // flat lane of the selected line
    wire [5:0] sel_pos = 6'({selb_r, sel_r[2:0]});

    ////////////////////////////////////////////////////////////////
    // interrupt lines: block 1 pins
    // all pins are synchronised so block input reads are safe too;
    // only block 1 lanes feed the edge detectors
    bdio_sync2 #(.W(N)) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .d(line_in),
        .q(in_s)
    );

    // one detector per interrupt-capable line, frozen with ce
    // detector state starts at the idle pin level, low
    logic [7:0] hit;
    generate
        for (g = 0; g < BDIO_BW; g++) begin : g_edge
            bdio_edge u_edge (
                .hclk(hclk),
                .hresetn(hresetn),
                .ce(ce),
                .s(in_s[BDIO_BW + g]),
                .trig(trig_r[2*g +: 2]),
                .hit(hit[g])
            );
        end
    endgenerate

    // only enabled lines of an input block count
    // an output block echoes its own level, so its edges are ignored
    wire [7:0] fire = hit & en_r & {8{dir_r[BDIO_IRQ_BLK]}};

    // lowest firing line reported
    // the others still set their status bits; the loop runs
    // downward so the last match is the lowest digit
    logic [3:0] fire_idx;
    always_comb begin
        fire_idx = 4'h0;
        for (int i = BDIO_BW - 1; i >= 0; i--) begin
            if (fire[i]) begin
                fire_idx = 4'(i);
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // enables and trigger types
    // an enable command also loads that line's trigger type;
    // trigger code 3 is reserved, so such a command is dropped whole
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            en_r <= 8'h00;
            trig_r <= BDIO_TRIG_RST;
        end else if (ce) begin
            // direct trigger register write
            if (w_trig) begin
                trig_r <= wd[15:0];
            end
            if (w_cmd && c_irqok && (bdio_op_t'(c_op) == BDIO_OP_IRQ_EN) && (c_trig != 2'h3)) begin
                en_r[c_line[2:0]] <= 1'b1;
                trig_r[2*c_line[2:0] +: 2] <= c_trig;
            end else if (w_cmd && c_irqok && (bdio_op_t'(c_op) == BDIO_OP_IRQ_DIS)) begin
                en_r[c_line[2:0]] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // sticky status; set wins over write-one clear
    // a clear meeting a new edge loses, so no event is missed
    logic [7:0] stat_nxt;
    assign stat_nxt = (stat_r & ~(w_stat ? wd[7:0] : 8'h00)) | fire;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stat_r <= 8'h00;
            mask_r <= 8'h00;
            src_r <= 4'h0;
        end else if (ce) begin
            stat_r <= stat_nxt;
            // interrupt mask
            if (w_mask) begin
                mask_r <= wd[7:0];
            end
            if (|fire) begin
                src_r <= fire_idx;
            end
        end
    end

    // one shared level interrupt
    // next status is used so irq rises with its status bit;
    // a mask change shows one cycle after it is written
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else if (ce) begin
            irq <= |(stat_nxt & mask_r);
        end
    end

    ////////////////////////////////////////////////////////////////
    // read path
    // read data is formed in the address phase and registered,
    // so it stands for the whole data phase
    wire rd_ap = ap_valid & ~hwrite;
    wire [7:0] ra = haddr[7:0];
    wire [7:0] in_rel = ra - BDIO_IN0_OFF;
    wire [7:0] ro_rel = ra - BDIO_OUT0_OFF;
    wire ra_in = (ra >= BDIO_IN0_OFF) & (in_rel[7:2] < 6'(BDIO_NBLK));
    wire ra_out = (ra >= BDIO_OUT0_OFF) & (ro_rel[7:2] < 6'(BDIO_NBLK));
    logic [31:0] rd_nxt;
    always_comb begin
        // offsets outside every window read as zero
        rd_nxt = 32'h0000_0000;
        if (ra == BDIO_DIR_OFF) begin
            rd_nxt = {26'h0, dir_r};
        end else if (ra == BDIO_STAT_OFF) begin
            rd_nxt = {24'h0, stat_r};
        end else if (ra == BDIO_MASK_OFF) begin
            rd_nxt = {24'h0, mask_r};
        end else if (ra == BDIO_TRIG_OFF) begin
            rd_nxt = {16'h0, trig_r};
        end else if (ra == BDIO_SRC_OFF) begin
            // line number in decimal form: 1x
            rd_nxt = {16'h0, en_r, 4'h1, src_r};
        end else if (ra == BDIO_RDBK_OFF) begin
            rd_nxt = {31'h0, out_r[sel_pos]};
        end else if (ra_out) begin
            rd_nxt = {24'h0, out_r[ro_rel[4:2]*BDIO_BW +: BDIO_BW]};
        end else if (ra_in) begin
            // block input levels, already synchronised
            rd_nxt = {24'h0, in_s[in_rel[4:2]*BDIO_BW +: BDIO_BW]};
        end
    end

    // read data register; holds until the next read
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (ce && rd_ap) begin
            hrdata <= rd_nxt;
        end
    end
endmodule : bdio_top
`default_nettype wire
